// file: hw/qdsl_defs.vh
// Constants for the quad converter serial load port
`ifndef QDSL_DEFS_VH
`define QDSL_DEFS_VH

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define QDSL_WORD_W      16
`define QDSL_DATA_W      12
`define QDSL_CHAN_HI     15
`define QDSL_CHAN_LO     14
`define QDSL_CMD_HI      13
`define QDSL_CMD_LO      12

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define QDSL_CMD_INPUT   2'h0
`define QDSL_CMD_DIRECT  2'h1
`define QDSL_CMD_UPDATE  2'h2
`define QDSL_CMD_EDGE    2'h3

// ----------------------------------------------------------------
// Register map and reset values
// ----------------------------------------------------------------
`define QDSL_REG_CTRL    4'h0
`define QDSL_REG_STAT    4'h4
`define QDSL_REG_WORD    4'h8
`define QDSL_CTRL_RST    1'h1
`define QDSL_RESP_OKAY   2'h0
`define QDSL_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define QDSL_CLK_NS      10
`define QDSL_GUARD_NS    35
`define QDSL_GUARD_CYC   ((`QDSL_GUARD_NS + `QDSL_CLK_NS - 1) / `QDSL_CLK_NS)

`endif

// file: hw/qdsl_port.v
// Serial load port of a four channel 12-bit converter, with AXI4-Lite status
`include "qdsl_defs.vh"
`default_nettype none

module qdsl_port #(
   parameter DATA_W = `QDSL_DATA_W
) (
   input  wire                 ref_clk,
   input  wire                 rst,
   // Serial link pins
   // (inputs all asynchronous to ref_clk, synchronised below)
   input  wire                 select_n,
   input  wire                 shift_clk,
   input  wire                 serial_in,
   input  wire                 load_all_strobe_n,
   output reg                  serial_echo_out,
   // Converter codes, channel 0 in the low bits
   // (one register per channel, updated by direct and update words and on strobe or software load-all)
   output reg  [4*DATA_W-1:0]  conv_codes,
   // AXI4-Lite slave
   input  wire [3:0]           s_axi_awaddr,
   input  wire                 s_axi_awvalid,
   output wire                 s_axi_awready,
   input  wire [31:0]          s_axi_wdata,
   input  wire [3:0]           s_axi_wstrb,
   input  wire                 s_axi_wvalid,
   output wire                 s_axi_wready,
   output reg  [1:0]           s_axi_bresp,
   output reg                  s_axi_bvalid,
   input  wire                 s_axi_bready,
   input  wire [3:0]           s_axi_araddr,
   input  wire                 s_axi_arvalid,
   output wire                 s_axi_arready,
   output reg  [31:0]          s_axi_rdata,
   output reg  [1:0]           s_axi_rresp,
   output reg                  s_axi_rvalid,
   input  wire                 s_axi_rready
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   reg  [3:0]  meta_r;      // First stage, read only by second stage
   reg  [3:0]  sync_r;      // Second stage: sel, clk, din, load
   reg         clk_d_r;     // Previous synchronised shift clock
   reg         sel_d_r;     // Previous synchronised select

   // Two flops on every pin, since the host runs on its own clock.
   // Reset levels match the idle pins (clock low, the rest high), so
   // no false edge is seen in the first cycles after reset
   always @(posedge ref_clk) begin
      if (rst) begin
         meta_r  <= 4'hD;
         sync_r  <= 4'hD;
         clk_d_r <= 1'b0;
         sel_d_r <= 1'b1;
      end else begin
         meta_r  <= {load_all_strobe_n, serial_in, shift_clk, select_n};
         sync_r  <= meta_r;
         clk_d_r <= sync_r[1];
         sel_d_r <= sync_r[0];
      end
   end

   // Edge of a sampled level
   // Used for both edges of both the select and the shift clock
   function rise_of;
      input now_v;
      input old_v;
      begin
         rise_of = now_v & ~old_v;
      end
   endfunction

   // Every detected edge lags its pin by two cycles; select and clock
   // share that lag, so their order at the pins is kept
   wire sel_low   = ~sync_r[0];
   wire sel_rise  = rise_of(sync_r[0], sel_d_r);
   wire sel_fall  = rise_of(sel_d_r, sync_r[0]);
   wire sclk_rise = rise_of(sync_r[1], clk_d_r);
   wire sclk_fall = rise_of(clk_d_r, sync_r[1]);
   wire load_low  = ~sync_r[3];

   // ----------------------------------------------------------------
   // Control state
   // ----------------------------------------------------------------
   // Frame state lives on ref_clk; the shift clock is only an input
   // whose edges are found by sampling
   reg  [15:0]       shift_r;     // Data-in / data-out shift register
   reg  [4:0]        bits_r;      // Bits shifted this frame
   reg  [2:0]        guard_r;     // Quiet time after select rises
   reg               edge_rise_r; // 1: echo on rising clock edge
   reg               enable_r;    // Software enable of the port
   reg               soft_load_r; // Software load-all request
   reg  [15:0]       last_word_r; // Last latched word
   reg  [15:0]       frames_r;    // Frames latched
   reg               short_r;     // Last frame was not 16 bits
   reg  [DATA_W-1:0] inp_r [0:3]; // Input registers
   integer           i;           // Loop index of the frame process
   integer           j;           // Loop index of the converter process

   // Guard length in cycles, cut to the counter width on purpose
   localparam [31:0] GUARD_FULL = `QDSL_GUARD_CYC;
   localparam [2:0]  GUARD_CYC  = GUARD_FULL[2:0];

   wire [1:0]        cmd  = shift_r[`QDSL_CMD_HI:`QDSL_CMD_LO];
   wire [1:0]        chan = shift_r[`QDSL_CHAN_HI:`QDSL_CHAN_LO];
   wire              shift_go = sel_low && sclk_rise && enable_r && (guard_r == 3'h0);

   // ----------------------------------------------------------------
   // Shift register, echo output and frame latch
   // ----------------------------------------------------------------
   // Shifting only while selected; a clock edge sampled while select is
   // high never enters, which covers edges before the fall and after the rise
   // The bit counter saturates so an overlong frame is also refused
   always @(posedge ref_clk) begin
      if (rst) begin
         shift_r         <= 16'h0000;
         bits_r          <= 5'h00;
         guard_r         <= 3'h0;
         serial_echo_out <= 1'b1;
         edge_rise_r     <= 1'b0;
         last_word_r     <= 16'h0000;
         frames_r        <= 16'h0000;
         short_r         <= 1'b0;
         for (i = 0; i < 4; i = i + 1) begin
            inp_r[i] <= {DATA_W{1'b0}};
         end
      end else begin
         // Guard window counts down after select rises; it keeps running
         // if select falls again early, so a clock edge hard after the
         // rise can never start the next word
         if (sel_rise) begin
            guard_r <= GUARD_CYC;
         end else if (guard_r != 3'h0) begin
            guard_r <= guard_r - 3'h1;
         end
         if (sel_fall) begin
            bits_r <= 5'h00;
         end
         if (shift_go) begin
            shift_r <= {shift_r[14:0], sync_r[2]};
            if (bits_r != 5'h1F) begin
               bits_r <= bits_r + 5'h01;
            end
         end
         // Echo output: high while deselected or disabled, else end of shift chain
         // On select fall the old end bit shows before the first clock
         if (!sel_low || !enable_r) begin
            serial_echo_out <= 1'b1;
         end else if (sel_fall) begin
            serial_echo_out <= shift_r[15];
         end else if (edge_rise_r && shift_go) begin
            serial_echo_out <= shift_r[14];
         end else if (!edge_rise_r && sclk_fall) begin
            serial_echo_out <= shift_r[15];
         end
         // Latch on select rising edge; a short frame is dropped
         // whole, since a partial word would load a wrong channel or code
         if (sel_rise && enable_r) begin
            if (bits_r == 5'h10) begin
               last_word_r <= shift_r;
               frames_r    <= frames_r + 16'h0001;
               short_r     <= 1'b0;
               case (cmd)
                  `QDSL_CMD_INPUT, `QDSL_CMD_DIRECT: begin
                     inp_r[chan] <= shift_r[DATA_W-1:0];
                  end
                  `QDSL_CMD_EDGE: begin
                     edge_rise_r <= shift_r[0];
                  end
                  default: begin
                     // Update command writes no input register
                  end
               endcase
            end else if (bits_r != 5'h00) begin
               short_r <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Converter registers
   // ----------------------------------------------------------------
   // The strobe acts on its level, so held low the converters follow
   // their input registers one cycle after any update
   // A software load pulse does the same for one cycle; both win over
   // a frame update in the same cycle
   always @(posedge ref_clk) begin
      if (rst) begin
         conv_codes <= {4*DATA_W{1'b0}};
      end else if (load_low || soft_load_r) begin
         for (j = 0; j < 4; j = j + 1) begin
            conv_codes[j*DATA_W +: DATA_W] <= inp_r[j];
         end
      end else if (sel_rise && enable_r && bits_r == 5'h10) begin
         if (cmd == `QDSL_CMD_DIRECT) begin
            conv_codes[chan*DATA_W +: DATA_W] <= shift_r[DATA_W-1:0];
         end else if (cmd == `QDSL_CMD_UPDATE) begin
            for (j = 0; j < 4; j = j + 1) begin
               conv_codes[j*DATA_W +: DATA_W] <= inp_r[j];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   reg         aw_full_r;   // Write address held
   reg  [3:0]  aw_addr_r;
   reg         w_full_r;    // Write data held
   reg  [31:0] w_data_r;
   reg  [3:0]  w_strb_r;

   assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_r && !s_axi_bvalid;

   // Address and data accepted in either order; response follows both
   // Only one write is held at a time: both readies drop while a
   // response waits, which keeps the slave free of a second buffer
   always @(posedge ref_clk) begin
      if (rst) begin
         aw_full_r    <= 1'b0;
         aw_addr_r    <= 4'h0;
         w_full_r     <= 1'b0;
         w_data_r     <= 32'h00000000;
         w_strb_r     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `QDSL_RESP_OKAY;
         enable_r     <= `QDSL_CTRL_RST;
         soft_load_r  <= 1'b0;
      end else begin
         soft_load_r <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (aw_full_r && w_full_r) begin
            aw_full_r    <= 1'b0;
            w_full_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_r == `QDSL_REG_CTRL) begin
               s_axi_bresp <= `QDSL_RESP_OKAY;
               if (w_strb_r[0]) begin
                  enable_r    <= w_data_r[0];
                  soft_load_r <= w_data_r[1];
               end
            end else begin
               s_axi_bresp <= `QDSL_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   // Shift path, status and enable are visible; converter values are not readable
   // Read data are registered and answer one cycle after the address
   // is taken; a new address waits until the data are accepted
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge ref_clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `QDSL_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `QDSL_RESP_OKAY;
         case (s_axi_araddr)
            `QDSL_REG_CTRL: begin
               s_axi_rdata <= {30'h00000000, 1'b0, enable_r};
            end
            `QDSL_REG_STAT: begin
               s_axi_rdata <= {frames_r, 8'h00, 2'h0, short_r, edge_rise_r,
                               sel_low, 3'h0};
            end
            `QDSL_REG_WORD: begin
               s_axi_rdata <= {shift_r, last_word_r};
            end
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `QDSL_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// file: verif/qdsl_port_chk.sv
// Assertion checker for the serial load port
`default_nettype none
module qdsl_port_chk #(
   parameter int DATA_W = 12
) (
   input wire logic                ref_clk,
   input wire logic                rst,
   input wire logic                select_n,
   input wire logic                load_all_strobe_n,
   input wire logic                serial_echo_out,
   input wire logic [4*DATA_W-1:0] conv_codes,
   input wire logic                s_axi_awvalid,
   input wire logic                s_axi_awready,
   input wire logic                s_axi_wvalid,
   input wire logic                s_axi_wready,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_bready,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_rready
);
   timeunit 1ns / 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ------
   // Steps
   // ------
   // Long enough for the pin synchronisers to settle
   sequence s_idle;
      select_n [*6];
   endsequence
   sequence s_quiet;
      (!select_n && load_all_strobe_n) [*8];
   endsequence
   sequence s_held;
      (select_n && !load_all_strobe_n) [*8];
   endsequence
   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   AST_ECHO_IDLE: assert property (s_idle |-> serial_echo_out)
      else $error("echo low while deselected");
   AST_CONV_FRAME: assert property (s_quiet |=> $stable(conv_codes))
      else $error("codes moved inside a frame");
   AST_CONV_STROBE: assert property (s_held |=> $stable(conv_codes))
      else $error("codes moved with strobe low");
   AST_B_NEXT: assert property (s_wr |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
endmodule
bind qdsl_port qdsl_port_chk #(.DATA_W(DATA_W)) u_chk (.ref_clk, .rst, .select_n,
   .load_all_strobe_n, .serial_echo_out, .conv_codes, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// file: verif/qdsl_host_model.sv
// Serial host model driving the load port pins
`default_nettype none
module qdsl_host_model (
   input  wire logic ref_clk,
   input  wire logic serial_echo_out,
   output var logic  select_n,
   output var logic  shift_clk,
   output var logic  serial_in
);
   timeunit 1ns / 1ps;
   initial begin
      select_n = 1'h1;
      shift_clk = 1'h0;
      serial_in = 1'h1;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // One frame of n bits, MSB first; the clock also pulses outside the frame
   task automatic frame(input logic [15:0] w, input int n, output logic [15:0] back);
      back = 16'h0;
      shift_clk <= 1'h1;
      cyc(8);
      shift_clk <= 1'h0;
      cyc(8);
      select_n <= 1'h0;
      cyc(8);
      for (int i = 0; i < n; i++) begin
         serial_in <= w[15-i];
         cyc(8);
         back = {back[14:0], serial_echo_out};
         shift_clk <= 1'h1;
         cyc(8);
         shift_clk <= 1'h0;
      end
      cyc(8);
      // Released data line must not keep the last bit
      serial_in <= ~serial_in;
      select_n <= 1'h1;
      cyc(8);
      shift_clk <= 1'h1;
      cyc(8);
      shift_clk <= 1'h0;
      cyc(8);
   endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the serial load port
`default_nettype none
module tb;
   timeunit 1ns / 1ps;
   logic        ref_clk = 1'h0;
   logic        rst = 1'h1;
   logic        load_all_strobe_n = 1'h1;
   logic        select_n, shift_clk, serial_in, serial_echo_out;
   logic [47:0] conv_codes;
   logic [47:0] exp_conv = 48'h0;  // Expected converter codes
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] back, prev;        // Echoed word and the word sent before
   logic        skip = 1'h1;       // Echo chain broken, no compare
   int          miscompares = 0, cmp_count = 0;
   always #5 ref_clk = ~ref_clk;
   qdsl_port uut (.ref_clk, .rst, .select_n, .shift_clk, .serial_in, .load_all_strobe_n,
      .serial_echo_out, .conv_codes, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   qdsl_host_model u_host (.ref_clk, .serial_echo_out, .select_n, .shift_clk, .serial_in);
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One bus access; ready sampled mid-cycle, signals moved after the edge
   task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] er);
      logic ta, tw, tq, tr;
      // One edge first, so two calls never drive a signal twice in one step
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      tr = 1'h0;
      while (!tr) begin
         @(negedge ref_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tq = s_axi_arvalid && s_axi_arready;
         tr = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
         if (tr) chk(w ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}, {er, w ? 32'h0 : d});
         @(posedge ref_clk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         if (tq) s_axi_arvalid <= 1'h0;
         if (tr) {s_axi_bready, s_axi_rready} <= 2'h0;
      end
   endtask
   // Frame through the host; echo returns the leading n bits of the last word
   task automatic send(input logic [15:0] w, input int n);
      u_host.frame(w, n, back);
      if (!skip) chk(back, prev >> (16 - n));
      skip = (n != 16);
      prev = w;
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'h0;
      repeat (4) @(posedge ref_clk);
      chk(conv_codes, exp_conv);
      axi(1'h0, 4'h0, 32'h1, 2'h0);   // Control resets enabled
      axi(1'h0, 4'hC, 32'h0, 2'h2);   // Unmapped place
      axi(1'h1, 4'h4, 32'hF, 2'h2);   // Status is read-only
      for (int c = 0; c < 4; c++) begin
         send({c[1:0], 2'h1, 12'hFFC + c[11:0]}, 16);
         exp_conv[12*c +: 12] = 12'hFFC + c[11:0];
         chk(conv_codes, exp_conv);
      end
      send(16'h0123, 16);
      chk(conv_codes, exp_conv);
      send(16'hE000, 16);
      exp_conv[11:0] = 12'h123;
      chk(conv_codes, exp_conv);
      send(16'h4ABC, 16);
      chk(conv_codes, exp_conv);
      load_all_strobe_n <= 1'h0;
      repeat (10) @(posedge ref_clk);
      exp_conv[23:12] = 12'hABC;
      chk(conv_codes, exp_conv);
      send(16'h8000, 16);
      exp_conv[35:24] = 12'h000;
      chk(conv_codes, exp_conv);
      load_all_strobe_n <= 1'h1;
      send(16'h1000, 8);
      chk(conv_codes, exp_conv);
      axi(1'h0, 4'h4, 32'h00080020, 2'h0);
      axi(1'h1, 4'h0, 32'h0, 2'h0);
      send(16'h1000, 16);
      chk(conv_codes, exp_conv);
      chk(back, 16'hFFFF);
      skip = 1'h1;
      axi(1'h1, 4'h0, 32'h1, 2'h0);
      send(16'h3001, 16);
      send(16'h1777, 16);
      exp_conv[11:0] = 12'h777;
      chk(conv_codes, exp_conv);
      send(16'h3000, 16);
      send(16'h5222, 16);
      exp_conv[23:12] = 12'h222;
      chk(conv_codes, exp_conv);
      send(16'h0456, 16);
      chk(conv_codes, exp_conv);
      axi(1'h1, 4'h0, 32'h3, 2'h0);
      axi(1'h0, 4'h8, 32'h04560456, 2'h0);
      axi(1'h0, 4'h4, 32'h000D0000, 2'h0);
      exp_conv[11:0] = 12'h456;
      chk(conv_codes, exp_conv);
      test_done();
   end
   initial begin
      repeat (30000) @(posedge ref_clk);
      miscompares++;
      test_done();
   end
endmodule
`default_nettype wire
